// ==== toc_dummy_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== toc_pkg.sv ====
`default_nettype none
package toc_pkg;
  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [11:0] TOC_OFF_CTRL = 12'h0030;
  localparam logic [11:0] TOC_OFF_MODE_HI = 12'h0034;
  localparam logic [11:0] TOC_OFF_CMP_A = 12'h0038;
  localparam logic [11:0] TOC_OFF_CMP_B = 12'h003C;
  localparam logic [11:0] TOC_OFF_COUNT = 12'h0040;
  localparam logic [11:0] TOC_OFF_STATUS = 12'h0044;
  // --------------------------------------------------------------------
  // fields and reset values
  // --------------------------------------------------------------------
  localparam int TOC_ACT_A_LSB = 6;
  localparam int TOC_ACT_B_LSB = 4;
  localparam int TOC_MODE_LSB = 0;
  localparam logic [7:0] TOC_CTRL_WMASK = 8'hF3;
  localparam logic [7:0] TOC_CTRL_RST = 8'h00;
  localparam int TOC_MODE_HI_BIT = 3;
  localparam logic [7:0] TOC_MAX = 8'hFF;
  localparam logic [7:0] TOC_BOTTOM = 8'h00;
  localparam logic [1:0] TOC_ACT_OFF = 2'b00;
  localparam logic [1:0] TOC_ACT_TGL = 2'b01;
  localparam logic [1:0] TOC_ACT_CLR = 2'b10;
  localparam logic [1:0] TOC_ACT_SET = 2'b11;
  // --------------------------------------------------------------------
  // wave modes
  // --------------------------------------------------------------------
  localparam logic [2:0] TOC_MODE_NORMAL = 3'h0;
  localparam logic [2:0] TOC_MODE_PC_MAX = 3'h1;
  localparam logic [2:0] TOC_MODE_CTC = 3'h2;
  localparam logic [2:0] TOC_MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] TOC_MODE_PC_CMP = 3'h5;
  localparam logic [2:0] TOC_MODE_FAST_CMP = 3'h7;
  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic data;
    logic dir;
  } toc_port_t;
  typedef struct packed {
    logic out;
    logic oe_n;
  } toc_pin_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic mode_hi;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] cnt;
    logic down;
    logic block;
    logic [1:0] wave;
    logic [31:0] prdata;
  } toc_state_t;
endpackage : toc_pkg
`default_nettype wire

// ==== toc_port_model.sv ====
`default_nettype none
module toc_port_model (
  // wave pins from the block
  input wire toc_pkg::toc_pin_t pin_a,
  input wire toc_pkg::toc_pin_t pin_b,
  // port settings made by software
  input wire logic [1:0] data,
  input wire logic [1:0] dir,
  // port register view
  output toc_pkg::toc_port_t port_a,
  output toc_pkg::toc_port_t port_b,
  // pad levels seen by the load
  output logic level_a,
  output logic level_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------
  // port bits and pad resolution
  // --------------------------------------------------------------------
  assign port_a = '{data: data[0], dir: dir[0]};
  assign port_b = '{data: data[1], dir: dir[1]};
  // the load pulls an undriven pad low
  assign level_a = pin_a.oe_n ? 1'b0 : pin_a.out;
  assign level_b = pin_b.oe_n ? 1'b0 : pin_b.out;
endmodule : toc_port_model
`default_nettype wire

// ==== toc_top.sv ====
// The APB slave port was chosen for this implementation.
`default_nettype none
module toc_top #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer tick, a clock enable
  input wire logic timer_tick,
  // port pin logic
  input wire toc_pkg::toc_port_t port_a,
  input wire toc_pkg::toc_port_t port_b,
  output toc_pkg::toc_pin_t pin_a,
  output toc_pkg::toc_pin_t pin_b
);
  // --------------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------------
  if (CNT_W != 8) begin : g_bad_width
    $error("toc_top supports only an 8-bit counter");
  end

  toc_pkg::toc_state_t st_ff;
  toc_pkg::toc_state_t nxt_st;

  // --------------------------------------------------------------------
  // channel action
  // --------------------------------------------------------------------
  function automatic logic toc_next(input logic cur, input logic [1:0] act, input logic is_a,
                                    input logic hi, input logic pc, input logic fast, input logic match,
                                    input logic wrap, input logic at_top, input logic cmp_top,
                                    input logic down);
    logic r;
    r = cur;
    if (act == toc_pkg::TOC_ACT_OFF) begin
      r = cur;
    end else if (!pc && !fast) begin
      if (match) begin
        case (act)
          toc_pkg::TOC_ACT_TGL: r = ~cur;
          toc_pkg::TOC_ACT_CLR: r = 1'b0;
          default: r = 1'b1;
        endcase
      end
    end else if (act == toc_pkg::TOC_ACT_TGL) begin
      if (is_a && hi && match) begin
        r = ~cur;
      end
    end else if (fast) begin
      if (match && !cmp_top) begin
        r = act[0];
      end
      if (wrap) begin
        r = ~act[0];
      end
    end else begin
      if (cmp_top) begin
        if (at_top) begin
          r = ~act[0];
        end
      end else if (match) begin
        r = down ? ~act[0] : act[0];
      end
    end
    return r;
  endfunction : toc_next

  // --------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------
  logic [2:0] mode;
  logic pc;
  logic fast;
  logic [7:0] top;
  logic at_top;
  logic wrap;
  logic tick;
  logic [1:0] act [2];
  logic [7:0] cmp [2];
  logic [1:0] mtch;
  logic [1:0] cmp_top;
  logic wr_acc;
  logic rd_setup;
  logic conn_a;

  always_comb begin
    mode = {st_ff.mode_hi, st_ff.ctrl[toc_pkg::TOC_MODE_LSB +: 2]};
    pc = (mode == toc_pkg::TOC_MODE_PC_MAX) || (mode == toc_pkg::TOC_MODE_PC_CMP);
    fast = (mode == toc_pkg::TOC_MODE_FAST_MAX) || (mode == toc_pkg::TOC_MODE_FAST_CMP);
    if (mode == toc_pkg::TOC_MODE_CTC || mode == toc_pkg::TOC_MODE_PC_CMP
        || mode == toc_pkg::TOC_MODE_FAST_CMP) begin
      top = st_ff.cmp_a;
    end else begin
      top = toc_pkg::TOC_MAX;
    end
    tick = timer_tick;
    at_top = tick && (st_ff.cnt == top);
    wrap = at_top && fast;
    act[0] = st_ff.ctrl[toc_pkg::TOC_ACT_A_LSB +: 2];
    act[1] = st_ff.ctrl[toc_pkg::TOC_ACT_B_LSB +: 2];
    conn_a = (act[0] != toc_pkg::TOC_ACT_OFF)
             && !((pc || fast) && act[0] == toc_pkg::TOC_ACT_TGL && !st_ff.mode_hi);
    cmp[0] = st_ff.cmp_a;
    cmp[1] = st_ff.cmp_b;
    for (int i = 0; i < 2; i++) begin
      mtch[i] = tick && !st_ff.block && (st_ff.cnt == cmp[i]);
      cmp_top[i] = (cmp[i] == top) && act[i][1];
    end
    wr_acc = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // counter
    if (tick) begin
      nxt_st.block = 1'b0;
      if (pc) begin
        if (!st_ff.down) begin
          if (st_ff.cnt == top && top != toc_pkg::TOC_BOTTOM) begin
            nxt_st.down = 1'b1;
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end
        end else begin
          if (st_ff.cnt == toc_pkg::TOC_BOTTOM) begin
            nxt_st.down = 1'b0;
            nxt_st.cnt = (top == toc_pkg::TOC_BOTTOM) ? toc_pkg::TOC_BOTTOM : 8'h01;
          end else begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end
        end
      end else begin
        nxt_st.down = 1'b0;
        nxt_st.cnt = (st_ff.cnt == top) ? toc_pkg::TOC_BOTTOM : st_ff.cnt + 8'h01;
      end
    end
    // outputs
    for (int i = 0; i < 2; i++) begin
      nxt_st.wave[i] = toc_next(st_ff.wave[i], act[i], (i == 0), st_ff.mode_hi, pc, fast, mtch[i],
                                wrap, at_top, cmp_top[i], st_ff.down);
    end
    // register writes
    if (wr_acc) begin
      if (paddr == toc_pkg::TOC_OFF_CTRL) begin
        nxt_st.ctrl = pwdata[7:0] & toc_pkg::TOC_CTRL_WMASK;
      end else if (paddr == toc_pkg::TOC_OFF_MODE_HI) begin
        nxt_st.mode_hi = pwdata[toc_pkg::TOC_MODE_HI_BIT];
      end else if (paddr == toc_pkg::TOC_OFF_CMP_A) begin
        nxt_st.cmp_a = pwdata[7:0];
      end else if (paddr == toc_pkg::TOC_OFF_CMP_B) begin
        nxt_st.cmp_b = pwdata[7:0];
      end else if (paddr == toc_pkg::TOC_OFF_COUNT) begin
        nxt_st.cnt = pwdata[7:0];
        nxt_st.block = 1'b1;
      end
    end
    // read data, captured in the setup cycle
    if (rd_setup) begin
      if (paddr == toc_pkg::TOC_OFF_CTRL) begin
        nxt_st.prdata = {24'h00_0000, st_ff.ctrl & toc_pkg::TOC_CTRL_WMASK};
      end else if (paddr == toc_pkg::TOC_OFF_MODE_HI) begin
        nxt_st.prdata = {28'h000_0000, st_ff.mode_hi, 3'h0};
      end else if (paddr == toc_pkg::TOC_OFF_CMP_A) begin
        nxt_st.prdata = {24'h00_0000, st_ff.cmp_a};
      end else if (paddr == toc_pkg::TOC_OFF_CMP_B) begin
        nxt_st.prdata = {24'h00_0000, st_ff.cmp_b};
      end else if (paddr == toc_pkg::TOC_OFF_COUNT) begin
        nxt_st.prdata = {24'h00_0000, st_ff.cnt};
      end else if (paddr == toc_pkg::TOC_OFF_STATUS) begin
        nxt_st.prdata = {28'h000_0000, st_ff.block, st_ff.down, st_ff.wave[1], st_ff.wave[0]};
      end else begin
        nxt_st.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------
  // bus answer and pins
  // --------------------------------------------------------------------
  always_comb begin
    prdata = st_ff.prdata;
    pready = 1'b1;
    if (paddr == toc_pkg::TOC_OFF_CTRL || paddr == toc_pkg::TOC_OFF_MODE_HI
        || paddr == toc_pkg::TOC_OFF_CMP_A || paddr == toc_pkg::TOC_OFF_CMP_B
        || paddr == toc_pkg::TOC_OFF_COUNT || paddr == toc_pkg::TOC_OFF_STATUS) begin
      pslverr = 1'b0;
    end else begin
      pslverr = psel && penable;
    end
    pin_a.out = conn_a ? st_ff.wave[0] : port_a.data;
    pin_a.oe_n = ~port_a.dir;
    pin_b.out = (act[1] != toc_pkg::TOC_ACT_OFF) ? st_ff.wave[1] : port_b.data;
    pin_b.oe_n = ~port_b.dir;
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fast_wrap_a(logic [1:0] code);
    fast && wrap && act[0] == code && !wr_acc;
  endsequence

  sequence s_pc_up_match_a(logic [1:0] code);
    pc && mtch[0] && !st_ff.down && !cmp_top[0] && act[0] == code && !wr_acc;
  endsequence

  AST_RESERVED_ZERO: assert property (
    rd_setup && paddr == toc_pkg::TOC_OFF_CTRL |=> prdata[3:2] == 2'b00 && prdata[7:4] == st_ff.ctrl[7:4])
    else $error("reserved control bits not zero on read");

  AST_PIN_A_SEL: assert property (
    act[0] != toc_pkg::TOC_ACT_OFF && !((pc || fast) && act[0] == toc_pkg::TOC_ACT_TGL && !st_ff.mode_hi)
    |-> pin_a.out == st_ff.wave[0] && pin_a.oe_n == !port_a.dir)
    else $error("pin A not driven from output A");

  AST_PIN_B_SEL: assert property (
    act[1] == toc_pkg::TOC_ACT_OFF |-> pin_b.out == port_b.data)
    else $error("pin B not returned to port");

  AST_NONPWM_TOGGLE_A: assert property (
    !pc && !fast && mtch[0] && act[0] == toc_pkg::TOC_ACT_TGL && !wr_acc |=> st_ff.wave[0] != $past(st_ff.wave[0]))
    else $error("output A did not toggle on match");

  AST_NONPWM_CLEAR_B: assert property (
    !pc && !fast && mtch[1] && act[1] == toc_pkg::TOC_ACT_CLR && !wr_acc |=> !st_ff.wave[1])
    else $error("output B not cleared on match");

  AST_FAST_SET_BOTTOM: assert property (
    s_fast_wrap_a(toc_pkg::TOC_ACT_CLR) |=> st_ff.wave[0] && st_ff.cnt == toc_pkg::TOC_BOTTOM)
    else $error("output A not set at bottom");

  AST_PWM_TGL_OFF: assert property (
    (pc || fast) && !st_ff.mode_hi && act[0] == toc_pkg::TOC_ACT_TGL && !wr_acc |=> $stable(st_ff.wave[0]))
    else $error("output A moved while code 01 disconnected");

  AST_PC_UP_CLEAR: assert property (
    s_pc_up_match_a(toc_pkg::TOC_ACT_CLR) |=> !st_ff.wave[0])
    else $error("output A not cleared on up-count match");

  AST_FAST_B_RSVD: assert property (
    fast && act[1] == toc_pkg::TOC_ACT_TGL && !wr_acc |=> $stable(st_ff.wave[1]))
    else $error("reserved code changed output B");

  AST_PC_B_RSVD: assert property (
    pc && act[1] == toc_pkg::TOC_ACT_TGL && !wr_acc |=> $stable(st_ff.wave[1]))
    else $error("reserved code changed output B");

  AST_FAST_TOP_IGNORE: assert property (
    fast && mtch[0] && cmp_top[0] && act[0] == toc_pkg::TOC_ACT_SET && !wr_acc |=> !st_ff.wave[0])
    else $error("match at top not ignored");

  AST_PC_TOP_ACTION: assert property (
    pc && at_top && cmp_top[0] && act[0] == toc_pkg::TOC_ACT_CLR && !wr_acc |=> st_ff.wave[0])
    else $error("action at top not done");

  AST_PC_TURN: assert property (
    pc && at_top && !st_ff.down && top != toc_pkg::TOC_BOTTOM && !wr_acc
    |=> st_ff.down && st_ff.cnt == $past(st_ff.cnt) - 8'h01)
    else $error("counter did not turn at top");

  AST_KEEP_STATE: assert property (
    act[0] == toc_pkg::TOC_ACT_OFF |=> st_ff.wave[0] == $past(st_ff.wave[0]))
    else $error("output A changed while disconnected");

  AST_NO_TICK_HOLD: assert property (
    !timer_tick && !wr_acc |=> st_ff.cnt == $past(st_ff.cnt) && $stable(st_ff.wave))
    else $error("state moved without a tick");

  sequence s_fast_wrap_b(logic [1:0] code);
    fast && wrap && act[1] == code && !wr_acc;
  endsequence

  sequence s_pc_down_match_a(logic [1:0] code);
    pc && mtch[0] && st_ff.down && !cmp_top[0] && act[0] == code && !wr_acc;
  endsequence

  AST_FAST_CLR_BOTTOM_B: assert property (
    s_fast_wrap_b(toc_pkg::TOC_ACT_SET) |=> !st_ff.wave[1])
    else $error("output B not cleared at bottom");

  AST_PC_DOWN_SET: assert property (
    s_pc_down_match_a(toc_pkg::TOC_ACT_CLR) |=> st_ff.wave[0])
    else $error("output A not set on down-count match");

  AST_FAST_MATCH_CLR: assert property (
    fast && mtch[0] && !cmp_top[0] && !wrap && act[0] == toc_pkg::TOC_ACT_CLR && !wr_acc |=> !st_ff.wave[0])
    else $error("output A not cleared on fast match");

  AST_NONPWM_SET_A: assert property (
    !pc && !fast && mtch[0] && act[0] == toc_pkg::TOC_ACT_SET && !wr_acc |=> st_ff.wave[0])
    else $error("output A not set on match");

  AST_NONPWM_TOGGLE_B: assert property (
    !pc && !fast && mtch[1] && act[1] == toc_pkg::TOC_ACT_TGL && !wr_acc |=> st_ff.wave[1] != $past(st_ff.wave[1]))
    else $error("output B did not toggle on match");

  AST_PWM_TGL_ON: assert property (
    (pc || fast) && st_ff.mode_hi && mtch[0] && act[0] == toc_pkg::TOC_ACT_TGL && !wr_acc
    |=> st_ff.wave[0] != $past(st_ff.wave[0]))
    else $error("output A did not toggle with mode high bit set");

  AST_PIN_A_OFF: assert property (
    (pc || fast) && !st_ff.mode_hi && act[0] == toc_pkg::TOC_ACT_TGL |-> pin_a.out == port_a.data)
    else $error("pin A not returned to port for code 01");

  AST_CTC_WRAP: assert property (
    mode == toc_pkg::TOC_MODE_CTC && at_top && !wr_acc |=> st_ff.cnt == toc_pkg::TOC_BOTTOM)
    else $error("counter did not clear at compare A");

  AST_FAST_TOP_IGNORE_B: assert property (
    fast && mtch[1] && cmp_top[1] && act[1] == toc_pkg::TOC_ACT_CLR && !wr_acc |=> st_ff.wave[1])
    else $error("match at top not ignored on B");

  AST_PC_TURN_UP: assert property (
    pc && tick && st_ff.down && st_ff.cnt == toc_pkg::TOC_BOTTOM && top != toc_pkg::TOC_BOTTOM && !wr_acc
    |=> !st_ff.down && st_ff.cnt == 8'h01)
    else $error("counter did not turn at bottom");

  AST_PC_TOP_ACTION_B: assert property (
    pc && at_top && cmp_top[1] && act[1] == toc_pkg::TOC_ACT_SET && !wr_acc |=> !st_ff.wave[1])
    else $error("action at top not done on B");

endmodule : toc_top
`default_nettype wire

// ==== toc_top_tb.sv ====
`default_nettype none
module toc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_tick, level_a, level_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] data, dir;
  toc_pkg::toc_port_t port_a, port_b;
  toc_pkg::toc_pin_t pin_a, pin_b;
  int errors = 0;
  int samples_checked = 0;
  localparam logic [1:0] CODES [3] = '{2'b01, 2'b10, 2'b11};
  localparam logic [1:0] EXPS [3] = '{2'b11, 2'b00, 2'b11};
  // --------------------------------------------------------------------
  // instances
  // --------------------------------------------------------------------
  toc_top u_toc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .port_a(port_a), .port_b(port_b), .pin_a(pin_a), .pin_b(pin_b));
  toc_port_model u_toc_port_model (.pin_a(pin_a), .pin_b(pin_b), .data(data), .dir(dir),
    .port_a(port_a), .port_b(port_b), .level_a(level_a), .level_b(level_b));
  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  task automatic step(input int n);
    @(posedge pclk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'b0;
  endtask : step
  task automatic hit(input logic [7:0] c, input int n);
    wr(toc_pkg::TOC_OFF_COUNT, {24'h00_0000, c});
    step(n);
  endtask : hit
  task automatic cmps(input logic [7:0] c);
    wr(toc_pkg::TOC_OFF_CMP_A, {24'h00_0000, c});
    wr(toc_pkg::TOC_OFF_CMP_B, {24'h00_0000, c});
  endtask : cmps
  task automatic wave(input logic [1:0] x);
    logic [31:0] r;
    rd(toc_pkg::TOC_OFF_STATUS, r);
    check({30'h0000_0000, r[1:0]}, {30'h0000_0000, x});
  endtask : wave
  task automatic pins(input logic [1:0] x);
    @(posedge pclk);
    check({30'h0000_0000, level_b, level_a}, {30'h0000_0000, x});
  endtask : pins
  task automatic do_reset(input int n);
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // --------------------------------------------------------------------
  // clock and watchdog
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    {psel, penable, pwrite, timer_tick, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    data = 2'b11;
    dir = 2'b11;
    do_reset(16);
    rd(toc_pkg::TOC_OFF_CTRL, r);
    check(r, 32'h0000_0000);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_00FF);
    rd(toc_pkg::TOC_OFF_CTRL, r);
    check(r, 32'h0000_00F3);
    apb(1'b0, 12'h100, 32'h0000_0000, r, e);
    check({31'h0000_0000, e}, 32'h0000_0001);
    pins(2'b00);
    check({30'h0000_0000, pin_b.oe_n, pin_a.oe_n}, 32'h0000_0000);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_0000);
    pins(2'b11);
    data <= 2'b00;
    cmps(8'h05);
    for (int i = 0; i < 3; i++) begin
      wr(toc_pkg::TOC_OFF_CTRL, {24'h00_0000, CODES[i], CODES[i], 4'h0});
      hit(8'h04, 2);
      wave(EXPS[i]);
      pins(EXPS[i]);
    end
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_0000);
    pins(2'b00);
    wave(2'b11);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_0050);
    pins(2'b11);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_0002);
    hit(8'h04, 2);
    rd(toc_pkg::TOC_OFF_COUNT, r);
    check(r, 32'h0000_0000);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_00B3);
    hit(8'h04, 2);
    wave(2'b10);
    cmps(8'hFF);
    hit(8'hFE, 2);
    wave(2'b01);
    cmps(8'h05);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_0053);
    hit(8'h04, 2);
    pins(2'b00);
    rd(toc_pkg::TOC_OFF_STATUS, r);
    wr(toc_pkg::TOC_OFF_MODE_HI, 32'h0000_0008);
    hit(8'h04, 2);
    wave({1'b0, ~r[0]});
    pins({1'b0, ~r[0]});
    rd(toc_pkg::TOC_OFF_COUNT, r);
    check(r, 32'h0000_0000);
    do_reset(4);
    cmps(8'h05);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_00B1);
    hit(8'h04, 2);
    wave(2'b10);
    hit(8'hFD, 3);
    rd(toc_pkg::TOC_OFF_COUNT, r);
    check(r, 32'h0000_00FE);
    rd(toc_pkg::TOC_OFF_STATUS, r);
    check({31'h0000_0000, r[2]}, 32'h0000_0001);
    cmps(8'hFC);
    step(3);
    wave(2'b01);
    do_reset(4);
    cmps(8'hFF);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_00A1);
    hit(8'hFD, 3);
    wave(2'b11);
    do_reset(4);
    cmps(8'h06);
    wr(toc_pkg::TOC_OFF_MODE_HI, 32'h0000_0008);
    wr(toc_pkg::TOC_OFF_CTRL, 32'h0000_00A1);
    hit(8'h05, 3);
    rd(toc_pkg::TOC_OFF_COUNT, r);
    check(r, 32'h0000_0004);
    wave(2'b11);
    complete_run();
  end
endmodule : toc_top_tb
`default_nettype wire
